// [logic/dag_addr_gen.sv]
// Decided for this implementation: the address map and the Wishbone slave port.
`timescale 1ns/10ps
`include "dag_regs.svh"

module dag_addr_gen
  import dag_pkg::*;
#(
  parameter int WB_AW = 8              // wishbone byte address width
)
(
  input  wire logic             i_clk,      // core clock
  input  wire logic             i_srst,     // sync reset, active high
  input  wire logic             i_wb_cyc,   // wishbone cycle
  input  wire logic             i_wb_stb,   // wishbone strobe
  input  wire logic             i_wb_we,    // wishbone write
  input  wire logic [WB_AW-1:0] i_wb_adr,   // wishbone byte address
  input  wire logic [31:0]      i_wb_dat,   // wishbone write data
  input  wire logic [3:0]       i_wb_sel,   // wishbone byte enables
  output logic      [31:0]      o_wb_dat,   // wishbone read data
  output logic                  o_wb_ack,   // wishbone acknowledge
  input  wire logic             i_acc_vld,  // access request valid
  input  wire dag_acc_t         i_acc,      // access request
  output dag_mem_t              o_mem,      // memory address/data buses
  input  wire logic [15:0]      i_rd_data,  // read_data_bus
  output logic                  o_rd_vld,   // read data captured
  output logic      [15:0]      o_rd_data   // captured read data
);

  logic [21:0] ptr_q [8];
  logic [2:0]  pointer_select_field_q;
  logic [15:0] page_pointer_q;
  logic [21:0] circ_top_q;
  logic [21:0] circ_bot_q;
  logic        ack_q;
  logic [31:0] wb_dat_q;
  logic [31:0] wb_rd_d;
  logic        wb_wr;
  logic        wb_rd;
  logic [2:0]  acc_idx;
  logic [21:0] cur_ptr;
  logic [21:0] next_ptr;
  logic [21:0] eff_addr;
  logic        uses_ptr;
  logic        ptr_upd;
  logic        rd_vld_q;
  logic [15:0] rd_data_q;
  dag_mem_t    mem_q;

  // merge a write into an old word under byte enables
  function automatic logic [31:0] wb_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        res[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return res;
  endfunction

  // wishbone: one request per ack, ack in the next cycle
  assign wb_wr = i_wb_cyc && i_wb_stb && !ack_q && i_wb_we;
  assign wb_rd = i_wb_cyc && i_wb_stb && !ack_q && !i_wb_we;

  // pointer named by the access: explicit or by the selector
  assign acc_idx  = (i_acc.mode == DAG_MODE_NAMED_IND) ? i_acc.ptr_idx :
                    pointer_select_field_q;
  assign cur_ptr  = ptr_q[acc_idx];
  assign uses_ptr = (i_acc.mode == DAG_MODE_SEL_IND) ||
                    (i_acc.mode == DAG_MODE_NAMED_IND) ||
                    (i_acc.mode == DAG_MODE_CIRC);
  assign ptr_upd  = i_acc_vld && uses_ptr &&
                    ((i_acc.modify != DAG_MOD_NONE) ||
                     (i_acc.mode == DAG_MODE_CIRC));

  // effective data-space address
  always_comb
  begin
    eff_addr = `DAG_RST_PTR;
    unique case (i_acc.mode)
      DAG_MODE_SEL_IND:   eff_addr = cur_ptr;
      DAG_MODE_NAMED_IND: eff_addr = cur_ptr;
      DAG_MODE_CIRC:      eff_addr = cur_ptr;
      DAG_MODE_PAGED:     eff_addr = {page_pointer_q,
                                      i_acc.offset};
      DAG_MODE_FIXED_ZERO_PAGE_MODE:     eff_addr = {`DAG_PAGE_ZERO, i_acc.offset};
      DAG_MODE_IMM:       eff_addr = {6'h00, i_acc.imm};
      default:            eff_addr = `DAG_RST_PTR;
    endcase
  end

  // post-modify arithmetic
  dag_ptr_alu u_alu (
    .i_ptr    (cur_ptr),
    .i_modify (i_acc.modify),
    .i_wide   (i_acc.wide),
    .i_circ   (i_acc.mode == DAG_MODE_CIRC),
    .i_top    (circ_top_q),
    .i_bot    (circ_bot_q),
    .o_next   (next_ptr)
  );

  // pointer registers; an access update beats a bus write
  for (genvar n = 0; n < 8; n++)
  begin : g_ptr
    always_ff @(posedge i_clk)
    begin
      if (i_srst)
        ptr_q[n] <= `DAG_RST_PTR;
      else if (ptr_upd && acc_idx == 3'(n))
        ptr_q[n] <= next_ptr;
      else if (wb_wr && i_wb_adr == WB_AW'(`DAG_OFS_PTR0 + 4 * n))
        ptr_q[n] <= 22'(wb_merge({10'h000, ptr_q[n]}, i_wb_dat,
                                 i_wb_sel));
    end
  end

  // selector field; a named access wins over a bus write
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      pointer_select_field_q <= `DAG_RST_SEL;
    else if (i_acc_vld && i_acc.mode == DAG_MODE_NAMED_IND)
      pointer_select_field_q <= i_acc.ptr_idx;
    else if (wb_wr && i_wb_adr == WB_AW'(`DAG_OFS_STATUS) && i_wb_sel[0])
      pointer_select_field_q <= i_wb_dat[`DAG_SEL_MSB:`DAG_SEL_LSB];
  end

  // page pointer and circular bounds, software written
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      page_pointer_q <= `DAG_RST_PAGE;
      circ_top_q     <= `DAG_RST_PTR;
      circ_bot_q     <= `DAG_RST_PTR;
    end
    else if (wb_wr)
    begin
      if (i_wb_adr == WB_AW'(`DAG_OFS_PAGE))
        page_pointer_q <= 16'(wb_merge({16'h0000, page_pointer_q},
                                       i_wb_dat, i_wb_sel));
      if (i_wb_adr == WB_AW'(`DAG_OFS_CTOP))
        circ_top_q <= 22'(wb_merge({10'h000, circ_top_q}, i_wb_dat,
                                   i_wb_sel));
      if (i_wb_adr == WB_AW'(`DAG_OFS_CBOT))
        circ_bot_q <= 22'(wb_merge({10'h000, circ_bot_q}, i_wb_dat,
                                   i_wb_sel));
    end
  end

  // memory buses, registered one cycle after the request
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      mem_q.rd_en   <= 1'b0;
      mem_q.rd_addr <= `DAG_RST_PTR;
      mem_q.wr_en   <= 1'b0;
      mem_q.wr_addr <= `DAG_RST_PTR;
      mem_q.wr_data <= `DAG_RST_DATA;
    end
    else
    begin
      mem_q.rd_en <= i_acc_vld && !i_acc.is_write;
      mem_q.wr_en <= i_acc_vld && i_acc.is_write;
      if (i_acc_vld && !i_acc.is_write)
        mem_q.rd_addr <= eff_addr;
      if (i_acc_vld && i_acc.is_write)
      begin
        mem_q.wr_addr <= eff_addr;
        mem_q.wr_data <= i_acc.wdata;
      end
    end
  end

  assign o_mem = mem_q;

  // read data is taken in the cycle the read address stands
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      rd_vld_q  <= 1'b0;
      rd_data_q <= `DAG_RST_DATA;
    end
    else
    begin
      rd_vld_q <= mem_q.rd_en;
      if (mem_q.rd_en)
        rd_data_q <= i_rd_data;
    end
  end

  assign o_rd_vld  = rd_vld_q;
  assign o_rd_data = rd_data_q;

  // register read mux; unmapped addresses read zero
  always_comb
  begin
    wb_rd_d = 32'h0000_0000;
    if (i_wb_adr >= WB_AW'(`DAG_OFS_PTR0) &&
        i_wb_adr <= WB_AW'(`DAG_OFS_PTR_END) && i_wb_adr[1:0] == 2'b00)
      wb_rd_d = {10'h000, ptr_q[i_wb_adr[4:2]]};
    else
    begin
      unique case (i_wb_adr)
        WB_AW'(`DAG_OFS_STATUS): wb_rd_d = {29'h0000_0000,
                                            pointer_select_field_q};
        WB_AW'(`DAG_OFS_PAGE):   wb_rd_d = {16'h0000, page_pointer_q};
        WB_AW'(`DAG_OFS_CTOP):   wb_rd_d = {10'h000, circ_top_q};
        WB_AW'(`DAG_OFS_CBOT):   wb_rd_d = {10'h000, circ_bot_q};
        WB_AW'(`DAG_OFS_RDATA):  wb_rd_d = {16'h0000, rd_data_q};
        default:                 wb_rd_d = 32'h0000_0000;
      endcase
    end
  end

  // wishbone ack and read data
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      ack_q    <= 1'b0;
      wb_dat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= i_wb_cyc && i_wb_stb && !ack_q;
      if (wb_rd)
        wb_dat_q <= wb_rd_d;
    end
  end

  assign o_wb_ack = ack_q;
  assign o_wb_dat = wb_dat_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  sequence s_named_acc;
    i_acc_vld && i_acc.mode == DAG_MODE_NAMED_IND;
  endsequence

  property p_sel_named;
    logic [2:0] n;
    (s_named_acc, n = i_acc.ptr_idx)
      |=> pointer_select_field_q == n &&
          (i_acc.mode != DAG_MODE_SEL_IND || acc_idx == n);
  endproperty
  a_sel_named: assert property (p_sel_named)
    else $error("selector not loaded by named access");

  property p_sel_rd;
    i_acc_vld && !i_acc.is_write && i_acc.mode == DAG_MODE_SEL_IND
      |=> o_mem.rd_en &&
          o_mem.rd_addr == $past(cur_ptr);
  endproperty
  a_sel_rd: assert property (p_sel_rd)
    else $error("selector read address wrong");

  property p_inc;
    ptr_upd && i_acc.modify == DAG_MOD_INC && i_acc.mode != DAG_MODE_CIRC
      |=> ptr_q[$past(acc_idx)] ==
          22'($past(cur_ptr) + ($past(i_acc.wide) ? 2 : 1));
  endproperty
  a_inc: assert property (p_inc)
    else $error("post increment step wrong");

  property p_dec;
    ptr_upd && i_acc.modify == DAG_MOD_DEC && i_acc.mode != DAG_MODE_CIRC
      |=> ptr_q[$past(acc_idx)] ==
          22'($past(cur_ptr) - ($past(i_acc.wide) ? 2 : 1));
  endproperty
  a_dec: assert property (p_dec)
    else $error("post decrement step wrong");

  property p_paged;
    i_acc_vld && !i_acc.is_write && i_acc.mode == DAG_MODE_PAGED
      |=> o_mem.rd_addr == {$past(page_pointer_q), $past(i_acc.offset)};
  endproperty
  a_paged: assert property (p_paged)
    else $error("paged address wrong");

  property p_fixed_zero_page_mode;
    i_acc_vld && i_acc.mode == DAG_MODE_FIXED_ZERO_PAGE_MODE
      |=> (o_mem.rd_en ? o_mem.rd_addr : o_mem.wr_addr) ==
          {16'h0000, $past(i_acc.offset)};
  endproperty
  a_fixed_zero_page_mode: assert property (p_fixed_zero_page_mode)
    else $error("page zero access left page 0");

  property p_imm;
    i_acc_vld && i_acc.mode == DAG_MODE_IMM && i_acc.is_write
      |=> o_mem.wr_en && o_mem.wr_addr == {6'h00, $past(i_acc.imm)};
  endproperty
  a_imm: assert property (p_imm)
    else $error("immediate address not zero extended");

  property p_circ;
    ptr_upd && i_acc.mode == DAG_MODE_CIRC && cur_ptr == circ_bot_q
      |=> ptr_q[$past(acc_idx)] == $past(circ_top_q);
  endproperty
  a_circ: assert property (p_circ)
    else $error("circular pointer not reloaded");

  property p_wr_bus;
    i_acc_vld && i_acc.is_write
      |=> o_mem.wr_en && !o_mem.rd_en &&
          o_mem.wr_data == $past(i_acc.wdata);
  endproperty
  a_wr_bus: assert property (p_wr_bus)
    else $error("write bus not driven");

  property p_rd_cap;
    o_mem.rd_en |=> o_rd_vld && o_rd_data == $past(i_rd_data);
  endproperty
  a_rd_cap: assert property (p_rd_cap)
    else $error("read data not captured");

endmodule

// [logic/dag_regs.svh]
`ifndef DAG_REGS_SVH
`define DAG_REGS_SVH

// register byte offsets on the wishbone slave
`define DAG_OFS_STATUS   8'h00
`define DAG_OFS_PAGE     8'h04
`define DAG_OFS_CTOP     8'h08
`define DAG_OFS_CBOT     8'h0C
`define DAG_OFS_RDATA    8'h10
`define DAG_OFS_PTR0     8'h20
`define DAG_OFS_PTR_END  8'h3C

// field positions in status_word_b
`define DAG_SEL_LSB      0
`define DAG_SEL_MSB      2

// widths of address, page and offset
`define DAG_AW           22
`define DAG_DW           16
`define DAG_OFF_W        6

// reset values
`define DAG_RST_PTR      22'h00_0000
`define DAG_RST_SEL      3'h0
`define DAG_RST_PAGE     16'h0000
`define DAG_RST_DATA     16'h0000

// pointer step per operand width
`define DAG_STEP_16      22'h00_0001
`define DAG_STEP_32      22'h00_0002

// fixed page used by the page-zero mode
`define DAG_PAGE_ZERO    16'h0000

`endif

// [logic/dag_pkg.sv]
package dag_pkg;

  // addressing modes of one access
  typedef enum logic [2:0] {
    DAG_MODE_SEL_IND   = 3'b000,
    DAG_MODE_NAMED_IND = 3'b001,
    DAG_MODE_PAGED     = 3'b010,
    DAG_MODE_FIXED_ZERO_PAGE_MODE     = 3'b011,
    DAG_MODE_IMM       = 3'b100,
    DAG_MODE_CIRC      = 3'b101
  } dag_mode_t;

  // pointer post-modification
  typedef enum logic [1:0] {
    DAG_MOD_NONE = 2'b00,
    DAG_MOD_INC  = 2'b01,
    DAG_MOD_DEC  = 2'b10
  } dag_mod_t;

  // one access request from the decode stage
  typedef struct packed {
    dag_mode_t   mode;
    dag_mod_t    modify;
    logic [2:0]  ptr_idx;
    logic        wide;
    logic        is_write;
    logic [5:0]  offset;
    logic [15:0] imm;
    logic [15:0] wdata;
  } dag_acc_t;

  // buses toward data memory
  typedef struct packed {
    logic        rd_en;
    logic [21:0] rd_addr;
    logic        wr_en;
    logic [21:0] wr_addr;
    logic [15:0] wr_data;
  } dag_mem_t;

endpackage

// [logic/dag_ptr_alu.sv]
`timescale 1ns/10ps
`include "dag_regs.svh"

// post-modify arithmetic for one pointer, with circular wrap
module dag_ptr_alu
  import dag_pkg::*;
(
  input  wire logic [21:0] i_ptr,    // current pointer value
  input  wire dag_mod_t    i_modify, // post-modification kind
  input  wire logic        i_wide,   // 32-bit operand
  input  wire logic        i_circ,   // circular mode
  input  wire logic [21:0] i_top,    // circular block top
  input  wire logic [21:0] i_bot,    // circular block bottom
  output logic      [21:0] o_next    // pointer after the access
);

  logic [21:0] step;

  // step size follows operand width
  assign step = i_wide ? `DAG_STEP_32 : `DAG_STEP_16;

  // next pointer value
  always_comb
  begin
    o_next = i_ptr;
    if (i_circ)
    begin
      if (i_ptr == i_bot)
        o_next = i_top;
      else
        o_next = i_ptr + step;
    end
    else
    begin
      unique case (i_modify)
        DAG_MOD_INC:  o_next = i_ptr + step;
        DAG_MOD_DEC:  o_next = i_ptr - step;
        DAG_MOD_NONE: o_next = i_ptr;
        default:      o_next = i_ptr;
      endcase
    end
  end

endmodule

// [tb/dag_mem_model.sv]
`timescale 1ns/10ps

// data memory behind the split read and write buses
module dag_mem_model
  import dag_pkg::*;
(
  input  wire logic     i_clk,     // core clock
  input  wire dag_mem_t i_mem,     // address and write buses
  output logic [15:0]   o_rd_data  // read_data_bus
);
  logic [15:0] mem [logic [21:0]];
  logic [15:0] last_q = 16'h0000;

  // store from the write buses, apart from the read address
  always @(posedge i_clk)
  begin
    if (i_mem.wr_en === 1'b1)
      mem[i_mem.wr_addr] = i_mem.wr_data;
    last_q <= o_rd_data;
  end

  // data only while a read is up, a moving pattern otherwise
  always @*
  begin
    if (i_mem.rd_en !== 1'b1)
      o_rd_data = ~last_q;
    else if (mem.exists(i_mem.rd_addr))
      o_rd_data = mem[i_mem.rd_addr];
    else
      o_rd_data = ~i_mem.rd_addr[15:0];
  end
endmodule

// [tb/dag_addr_gen_tb.sv]
`timescale 1ns/10ps

module dag_addr_gen_tb
  import dag_pkg::*;
;
  logic        i_clk = 1'b0;
  logic        i_srst;
  logic        i_wb_cyc;
  logic        i_wb_stb;
  logic        i_wb_we;
  logic [7:0]  i_wb_adr;
  logic [31:0] i_wb_dat;
  logic [3:0]  i_wb_sel;
  logic [31:0] o_wb_dat;
  logic        o_wb_ack;
  logic        i_acc_vld;
  dag_acc_t    i_acc;
  dag_mem_t    o_mem;
  logic [15:0] rd_bus;
  logic        o_rd_vld;
  logic [15:0] o_rd_data;
  logic [21:0] sp [8];
  logic [2:0]  sel;
  logic [15:0] pg;
  logic [21:0] top;
  logic [21:0] bot;
  logic [15:0] shadow [logic [21:0]];
  logic [38:0] eq [$];
  logic [38:0] e;
  logic        pend = 1'b0;
  logic [15:0] pdat;
  int          mismatches = 0;
  int          tests_run = 0;
  int          cyc_n = 0;
  int          n;

  dag_addr_gen #(.WB_AW(8)) i_dut (
    .i_clk(i_clk), .i_srst(i_srst), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
    .i_wb_dat(i_wb_dat), .i_wb_sel(i_wb_sel), .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack), .i_acc_vld(i_acc_vld), .i_acc(i_acc),
    .o_mem(o_mem), .i_rd_data(rd_bus), .o_rd_vld(o_rd_vld),
    .o_rd_data(o_rd_data));

  dag_mem_model i_memory (.i_clk(i_clk), .i_mem(o_mem), .o_rd_data(rd_bus));

  // core clock, 25 ns period
  always #12.5 i_clk = ~i_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] x);
    tests_run++;
    if (got !== x)
    begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, x);
    end
  endtask

  task automatic results;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // one wishbone classic cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] ad,
                    input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] r);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= we;
    i_wb_adr <= ad;
    i_wb_dat <= d;
    i_wb_sel <= s;
    do @(posedge i_clk); while (o_wb_ack !== 1'b1);
    r = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, ad, d, 4'hF, r);
  endtask

  task automatic rdc(input logic [7:0] ad, input logic [31:0] x);
    logic [31:0] r;
    wb(1'b0, ad, 32'h0000_0000, 4'hF, r);
    chk(r, x);
  endtask

  task automatic wp(input int k, input logic [21:0] v);
    wr(8'(32'h20 + k * 4), 32'(v));
    sp[k] = v;
  endtask

  // issue one access and queue the bus activity it must cause
  task automatic acc(input dag_mode_t m, input dag_mod_t md,
                     input logic [2:0] k0, input logic w,
                     input logic wr_n, input logic [15:0] v);
    dag_acc_t    a;
    logic [21:0] ea;
    logic [21:0] st;
    logic [2:0]  k;
    logic [15:0] d;
    st = w ? 22'h00_0002 : 22'h00_0001;
    k = (m == DAG_MODE_NAMED_IND) ? k0 : sel;
    ea = sp[k];
    case (m)
      DAG_MODE_SEL_IND, DAG_MODE_NAMED_IND:
      begin
        sel = k;
        if (md == DAG_MOD_INC) sp[k] = sp[k] + st;
        if (md == DAG_MOD_DEC) sp[k] = sp[k] - st;
      end
      DAG_MODE_PAGED: ea = {pg, v[5:0]};
      DAG_MODE_FIXED_ZERO_PAGE_MODE: ea = {16'h0000, v[5:0]};
      DAG_MODE_IMM: ea = {6'h00, v};
      default: sp[k] = (sp[k] == bot) ? top : sp[k] + st;
    endcase
    d = shadow.exists(ea) ? shadow[ea] : ~ea[15:0];
    if (wr_n) d = v;
    if (wr_n) shadow[ea] = v;
    eq.push_back({wr_n, ea, d});
    a = '0;
    a.mode = m;
    a.modify = md;
    a.ptr_idx = k0;
    a.wide = w;
    a.is_write = wr_n;
    a.offset = v[5:0];
    a.imm = v;
    a.wdata = v;
    i_acc <= a;
    i_acc_vld <= 1'b1;
    @(posedge i_clk);
  endtask

  task automatic idle;
    i_acc_vld <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic clr;
    foreach (sp[i]) sp[i] = 22'h00_0000;
    sel = 3'h0;
    pg = 16'h0000;
    top = 22'h00_0000;
    bot = 22'h00_0000;
  endtask

  // compare memory buses against the queue of expected accesses
  always @(negedge i_clk)
  begin
    if (pend)
    begin
      chk(32'(o_rd_vld), 32'h1);
      chk(32'(o_rd_data), 32'(pdat));
    end
    pend = 1'b0;
    if (o_mem.rd_en === 1'b1 || o_mem.wr_en === 1'b1)
    begin
      e = eq.pop_front();
      chk(32'(o_mem.wr_en), 32'(e[38]));
      chk(32'(o_mem.rd_en), 32'(!e[38]));
      chk(32'(e[38] ? o_mem.wr_addr : o_mem.rd_addr), 32'(e[37:16]));
      if (e[38]) chk(32'(o_mem.wr_data), 32'(e[15:0]));
      pend = !e[38];
      pdat = e[15:0];
    end
  end

  // cut a hang short
  always @(posedge i_clk)
  begin
    cyc_n++;
    if (cyc_n == 5000)
    begin
      mismatches++;
      results();
    end
  end

  // main sequence
  initial
  begin
    i_srst = 1'b1;
    i_wb_cyc = 1'b0;
    i_wb_stb = 1'b0;
    i_wb_we = 1'b0;
    i_wb_adr = 8'h00;
    i_wb_dat = 32'h0000_0000;
    i_wb_sel = 4'h0;
    i_acc_vld = 1'b0;
    i_acc = '0;
    clr();
    repeat (6) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    rdc(8'h00, 32'h0000_0000);
    rdc(8'h04, 32'h0000_0000);
    wr(8'h14, 32'h5A5A_5A5A);
    rdc(8'h14, 32'h0000_0000);
    wr(8'h10, 32'h0000_1234);
    rdc(8'h10, 32'h0000_0000);
    wr(8'h04, 32'h0000_01F4);
    pg = 16'h01F4;
    acc(DAG_MODE_PAGED, DAG_MOD_NONE, 3'h0, 1'b0, 1'b0, 16'h003F);
    acc(DAG_MODE_FIXED_ZERO_PAGE_MODE, DAG_MOD_INC, 3'h0, 1'b0, 1'b0, 16'h0015);
    idle();
    wr(8'h04, 32'h0000_FFFF);
    pg = 16'hFFFF;
    acc(DAG_MODE_PAGED, DAG_MOD_NONE, 3'h0, 1'b0, 1'b0, 16'h0000);
    acc(DAG_MODE_IMM, DAG_MOD_DEC, 3'h0, 1'b0, 1'b0, 16'hFFFF);
    acc(DAG_MODE_IMM, DAG_MOD_INC, 3'h0, 1'b0, 1'b1, 16'h8001);
    idle();
    for (n = 0; n < 8; n++)
    begin
      wp(n, {3'(n), 19'h0_0001});
      acc(DAG_MODE_NAMED_IND, n[1] ? DAG_MOD_DEC : DAG_MOD_INC,
          3'(n), n[0], 1'b1, 16'(16'hC000 + n));
      acc(DAG_MODE_SEL_IND, DAG_MOD_DEC, 3'h0, 1'b1, 1'b0,
          16'h0000);
      idle();
      rdc(8'h00, 32'(n));
      rdc(8'(32'h20 + n * 4), 32'(sp[n]));
    end
    acc(DAG_MODE_NAMED_IND, DAG_MOD_NONE, 3'h5, 1'b0, 1'b1, 16'hBEEF);
    acc(DAG_MODE_SEL_IND, DAG_MOD_NONE, 3'h0, 1'b0, 1'b0, 16'h0000);
    idle();
    rdc(8'h10, 32'h0000_BEEF);
    wb(1'b1, 8'h00, 32'h0000_0002, 4'h0, e[31:0]);
    rdc(8'h00, 32'h0000_0005);
    wb(1'b1, 8'h00, 32'h0000_0002, 4'h1, e[31:0]);
    sel = 3'h2;
    rdc(8'h00, 32'h0000_0002);
    top = 22'h00_0200;
    bot = 22'h00_0202;
    wr(8'h08, 32'(top));
    wr(8'h0C, 32'(bot));
    wp(2, top);
    repeat (4) acc(DAG_MODE_CIRC, DAG_MOD_INC, 3'h0, 1'b0, 1'b0,
                   16'h0000);
    idle();
    wp(2, top);
    repeat (3) acc(DAG_MODE_CIRC, DAG_MOD_DEC, 3'h0, 1'b1, 1'b0,
                   16'h0000);
    idle();
    i_srst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    clr();
    @(posedge i_clk);
    rdc(8'h00, 32'h0000_0000);
    rdc(8'h28, 32'h0000_0000);
    repeat (3) @(posedge i_clk);
    chk(32'(eq.size()), 32'h0);
    results();
  end
endmodule
